// ### flash_erase_protect_ctrl.sv
// Flash controller: block erase, programming and region protection
`timescale 1ns/1ps
`default_nettype none
module flash_erase_protect_ctrl
  import flash_pkg::*;
#(
  parameter int FLASH_SIZE = FLASH_BYTES,
  parameter int BLOCK_SIZE = BLOCK_BYTES
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire mem_req_t fetch_req,
  input wire mem_req_t data_req,
  input wire mem_req_t dbg_req,
  input wire logic erase_req,
  input wire logic [BLK_W-1:0] erase_blk_sel,
  input wire logic [REGIONS-1:0] ro_mask,
  input wire logic [REGIONS-1:0] xo_mask,
  input wire logic viol_clr,
  output mem_rsp_t fetch_rsp,
  output mem_rsp_t data_rsp,
  output mem_rsp_t dbg_rsp,
  output logic erase_busy,
  output logic erase_done,
  output logic viol_pulse,
  output logic viol_sticky
);
  localparam int DEPTH = FLASH_SIZE / WORD_BYTES;

  // Struct widths are fixed by the package, so sizes must agree with it
  if (FLASH_SIZE != FLASH_BYTES || BLOCK_SIZE != BLOCK_BYTES || REGION_BYTES != 2 * BLOCK_SIZE)
  begin : g_bad_size
    $error("flash_erase_protect_ctrl: unsupported array or block size");
  end

  logic [WORD_W-1:0] mem [DEPTH];

  erase_state_t state, next_state;
  logic [BLK_W-1:0] erase_blk, next_blk;
  logic [WPB_W-1:0] erase_ptr, next_ptr;
  logic next_busy, next_done, next_viol, next_sticky;
  mem_rsp_t next_fetch, next_data, next_dbg;
  logic mem_we;
  logic [WADDR_W-1:0] mem_waddr;
  logic [WORD_W-1:0] mem_wdata;
  logic wr_taken;
  logic erase_denied;

  logic [NREQ-1:0] allow;
  logic [REG_W-1:0] req_region [NREQ];
  src_t req_src [NREQ];
  op_t req_op [NREQ];

  always_comb
  begin
    req_region[REQ_FETCH] = fetch_req.addr[REG_LSB +: REG_W];
    req_region[REQ_DATA] = data_req.addr[REG_LSB +: REG_W];
    req_region[REQ_DEBUG] = dbg_req.addr[REG_LSB +: REG_W];
    req_region[REQ_ERASE] = erase_blk_sel[BLK_W-1:1];
    req_src[REQ_FETCH] = SRC_FETCH;
    req_src[REQ_DATA] = SRC_DATA;
    req_src[REQ_DEBUG] = SRC_DEBUG;
    req_src[REQ_ERASE] = SRC_DATA;
    req_op[REQ_FETCH] = OP_READ;
    req_op[REQ_DATA] = data_req.write ? OP_PROGRAM : OP_READ;
    req_op[REQ_DEBUG] = dbg_req.write ? OP_PROGRAM : OP_READ;
    req_op[REQ_ERASE] = OP_ERASE;
  end

  for (genvar g = 0; g < NREQ; g++)
  begin : g_guard
    protect_guard u_guard (
      .region(req_region[g]),
      .src(req_src[g]),
      .op(req_op[g]),
      .ro_mask(ro_mask),
      .xo_mask(xo_mask),
      .allow(allow[g])
    );
  end

  always_comb
  begin
    next_state = state;
    next_blk = erase_blk;
    next_ptr = erase_ptr;
    next_busy = erase_busy;
    next_done = 1'b0;
    next_fetch = '0;
    next_data = '0;
    next_dbg = '0;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = ERASED_WORD;
    wr_taken = 1'b0;
    erase_denied = 1'b0;
    // Fetch is never write-capable and may always read execute-only code
    if (fetch_req.valid)
    begin
      next_fetch.ack = allow[REQ_FETCH];
      next_fetch.denied = !allow[REQ_FETCH];
      if (allow[REQ_FETCH])
        next_fetch.rdata = mem[fetch_req.addr[ADDR_W-1:WORD_LSB]];
    end
    if (data_req.valid)
    begin
      if (!allow[REQ_DATA])
        next_data.denied = 1'b1;
      else if (!data_req.write)
      begin
        next_data.ack = 1'b1;
        next_data.rdata = mem[data_req.addr[ADDR_W-1:WORD_LSB]];
      end
      else if (state == ST_IDLE)
      begin
        // Programming only clears bits; only erase brings them back to one
        next_data.ack = 1'b1;
        wr_taken = 1'b1;
        mem_we = 1'b1;
        mem_waddr = data_req.addr[ADDR_W-1:WORD_LSB];
        mem_wdata = mem[mem_waddr] & data_req.wdata;
      end
    end
    if (dbg_req.valid)
    begin
      if (!allow[REQ_DEBUG])
        next_dbg.denied = 1'b1;
      else if (!dbg_req.write)
      begin
        next_dbg.ack = 1'b1;
        next_dbg.rdata = mem[dbg_req.addr[ADDR_W-1:WORD_LSB]];
      end
      else if (state == ST_IDLE && !wr_taken)
      begin
        next_dbg.ack = 1'b1;
        mem_we = 1'b1;
        mem_waddr = dbg_req.addr[ADDR_W-1:WORD_LSB];
        mem_wdata = mem[mem_waddr] & dbg_req.wdata;
      end
    end
    unique case (state)
      ST_IDLE:
      begin
        if (erase_req)
        begin
          if (!allow[REQ_ERASE])
            erase_denied = 1'b1;
          else
          begin
            next_state = ST_ERASE;
            next_blk = erase_blk_sel;
            next_ptr = '0;
            next_busy = 1'b1;
          end
        end
      end
      ST_ERASE:
      begin
        // One word per cycle, confined to the latched block
        mem_we = 1'b1;
        mem_waddr = {erase_blk, erase_ptr};
        mem_wdata = ERASED_WORD;
        next_ptr = erase_ptr + 1'b1;
        if (erase_ptr == LAST_PTR)
        begin
          next_state = ST_IDLE;
          next_busy = 1'b0;
          next_done = 1'b1;
        end
      end
    endcase
    next_viol = next_fetch.denied | next_data.denied | next_dbg.denied | erase_denied;
    // A new refusal wins over a clear in the same cycle
    next_sticky = (viol_sticky & ~viol_clr) | next_viol;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      erase_blk <= '0;
      erase_ptr <= '0;
      erase_busy <= 1'b0;
      erase_done <= 1'b0;
      fetch_rsp <= '0;
      data_rsp <= '0;
      dbg_rsp <= '0;
      viol_pulse <= 1'b0;
      viol_sticky <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      erase_blk <= next_blk;
      erase_ptr <= next_ptr;
      erase_busy <= next_busy;
      erase_done <= next_done;
      fetch_rsp <= next_fetch;
      data_rsp <= next_data;
      dbg_rsp <= next_dbg;
      viol_pulse <= next_viol;
      viol_sticky <= next_sticky;
    end
  end

  // Array contents survive reset, as flash does
  always_ff @(posedge sys_clk)
  begin
    if (rst_n && clk_en && mem_we)
      mem[mem_waddr] <= mem_wdata;
  end

  // Helper count of erase write cycles
  logic [WPB_W:0] erase_cnt, next_erase_cnt;
  always_comb
  begin
    next_erase_cnt = erase_cnt;
    if (state == ST_IDLE)
      next_erase_cnt = '0;
    else
      next_erase_cnt = erase_cnt + 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      erase_cnt <= '0;
    else if (clk_en)
      erase_cnt <= next_erase_cnt;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_erase_in_block;
    erase_busy |-> mem_we && mem_waddr[WADDR_W-1 -: BLK_W] == erase_blk;
  endproperty
  a_erase_in_block: assert property (p_erase_in_block) else $error("erase wrote outside its block");

  property p_erase_len;
    erase_done |-> erase_cnt == (WPB_W + 1)'(WPB) && !erase_busy;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase did not cover the whole block");

  property p_erase_ones;
    erase_busy |-> mem_wdata == ERASED_WORD;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erase wrote a zero bit");

  property p_region_pair;
    clk_en && erase_req && !erase_busy && (ro_mask[erase_blk_sel[BLK_W-1:1]] || xo_mask[erase_blk_sel[BLK_W-1:1]])
      |=> !erase_busy && viol_pulse;
  endproperty
  a_region_pair: assert property (p_region_pair) else $error("erase ran in a protected region");

  property p_ro_no_program;
    clk_en && !erase_busy && data_req.valid && data_req.write && ro_mask[data_req.addr[REG_LSB +: REG_W]]
      |-> !(mem_we && mem_waddr[WADDR_W-1 -: REG_W] == data_req.addr[REG_LSB +: REG_W])
      ##1 data_rsp.denied && !data_rsp.ack;
  endproperty
  a_ro_no_program: assert property (p_ro_no_program) else $error("program reached a read-only region");

  property p_ro_read_ok;
    clk_en && data_req.valid && !data_req.write && ro_mask[data_req.addr[REG_LSB +: REG_W]]
      && !xo_mask[data_req.addr[REG_LSB +: REG_W]] |=> data_rsp.ack && !data_rsp.denied;
  endproperty
  a_ro_read_ok: assert property (p_ro_read_ok) else $error("read of a read-only region refused");

  property p_xo_no_erase;
    clk_en && erase_req && !erase_busy && xo_mask[erase_blk_sel[BLK_W-1:1]] |=> !erase_busy ##1 !erase_done;
  endproperty
  a_xo_no_erase: assert property (p_xo_no_erase) else $error("erase ran in an execute-only region");

  property p_xo_data_read;
    clk_en && data_req.valid && !data_req.write && xo_mask[data_req.addr[REG_LSB +: REG_W]]
      |=> data_rsp.denied && data_rsp.rdata == '0;
  endproperty
  a_xo_data_read: assert property (p_xo_data_read) else $error("data read of execute-only code");

  property p_xo_dbg_read;
    clk_en && dbg_req.valid && !dbg_req.write && xo_mask[dbg_req.addr[REG_LSB +: REG_W]]
      |=> dbg_rsp.denied && !dbg_rsp.ack && dbg_rsp.rdata == '0;
  endproperty
  a_xo_dbg_read: assert property (p_xo_dbg_read) else $error("debug read of execute-only code");

  property p_fetch_single;
    clk_en && fetch_req.valid |=> fetch_rsp.ack && !fetch_rsp.denied;
  endproperty
  a_fetch_single: assert property (p_fetch_single) else $error("fetch not answered in one cycle");

  property p_viol_flag;
    clk_en && ((data_req.valid && !allow[REQ_DATA]) || (dbg_req.valid && !allow[REQ_DEBUG]))
      |=> viol_pulse && viol_sticky;
  endproperty
  a_viol_flag: assert property (p_viol_flag) else $error("refusal did not raise violation");
endmodule
`default_nettype wire

// ### flash_pkg.sv
// Shared constants and types for the flash erase and protection controller
package flash_pkg;
  localparam int FLASH_BYTES = 32768;
  localparam int BLOCK_BYTES = 1024;
  localparam int REGION_BYTES = 2048;
  localparam int WORD_BYTES = 4;
  localparam int ADDR_W = 15;
  localparam int WORD_W = 32;
  localparam int WADDR_W = 13;
  localparam int WORD_LSB = 2;
  localparam int BLK_W = 5;
  localparam int REG_W = 4;
  localparam int REG_LSB = 11;
  localparam int REGIONS = 16;
  localparam int WPB = 256;
  localparam int WPB_W = 8;
  localparam logic [WPB_W-1:0] LAST_PTR = 8'hff;
  localparam logic [WORD_W-1:0] ERASED_WORD = 32'hffffffff;
  localparam int NREQ = 4;
  localparam int REQ_FETCH = 0;
  localparam int REQ_DATA = 1;
  localparam int REQ_DEBUG = 2;
  localparam int REQ_ERASE = 3;

  typedef enum logic [1:0] {SRC_FETCH, SRC_DATA, SRC_DEBUG} src_t;
  typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_ERASE} op_t;
  typedef enum logic {ST_IDLE, ST_ERASE} erase_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic ack;
    logic denied;
    logic [WORD_W-1:0] rdata;
  } mem_rsp_t;
endpackage

// ### protect_guard.sv
// Region protection decision for one requester
`timescale 1ns/1ps
`default_nettype none
module protect_guard
  import flash_pkg::*;
(
  input wire logic [REG_W-1:0] region,
  input wire src_t src,
  input wire op_t op,
  input wire logic [REGIONS-1:0] ro_mask,
  input wire logic [REGIONS-1:0] xo_mask,
  output logic allow
);
  always_comb
  begin
    if (op == OP_READ)
      allow = !(xo_mask[region] && (src != SRC_FETCH));
    else
      allow = !(ro_mask[region] || xo_mask[region]);
  end
endmodule
`default_nettype wire

// ### flash_host_model.sv
// Fetch, data and debug requester model for the flash controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_model
  import flash_pkg::*;
(
  input wire logic sys_clk,
  output mem_req_t fetch_req,
  output mem_req_t data_req,
  output mem_req_t dbg_req
);
  initial
  begin
    fetch_req = '0;
    data_req = '0;
    dbg_req = '0;
  end
  task automatic put(input src_t s, input mem_req_t r);
    case (s)
      SRC_FETCH: fetch_req <= r;
      SRC_DATA: data_req <= r;
      default: dbg_req <= r;
    endcase
  endtask
  // Request held one cycle, taken at the following edge
  task automatic issue(input src_t s, input logic w, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge sys_clk);
    put(s, '{valid: 1'b1, write: w, addr: a, wdata: d});
    @(posedge sys_clk);
    // Released lines show inverted values so stale data cannot pass
    put(s, '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d});
  endtask
endmodule
`default_nettype wire

// ### test_flash_erase_protect_ctrl.sv
// Self-checking testbench for the flash erase and protection controller
`timescale 1ns/1ps
`default_nettype none
module test_flash_erase_protect_ctrl;
  import flash_pkg::*;
  logic sys_clk = 0;
  logic rst_n = 0;
  logic clk_en = 1;
  logic erase_req = 0;
  logic viol_clr = 0;
  logic [BLK_W-1:0] erase_blk_sel = '0;
  logic [REGIONS-1:0] ro_mask = '0;
  logic [REGIONS-1:0] xo_mask = '0;
  mem_req_t fetch_req, data_req, dbg_req;
  mem_rsp_t fetch_rsp, data_rsp, dbg_rsp;
  logic erase_busy, erase_done, viol_pulse, viol_sticky;
  int fails = 0;
  int n_checks = 0;
  // Expected contents of blocks 0 and 1 only, which make region 0
  logic [WORD_W-1:0] exp_mem [0:511];
  always #50 sys_clk = ~sys_clk;
  flash_host_model host (.sys_clk(sys_clk), .fetch_req(fetch_req), .data_req(data_req), .dbg_req(dbg_req));
  flash_erase_protect_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .fetch_req(fetch_req),
    .data_req(data_req), .dbg_req(dbg_req), .erase_req(erase_req), .erase_blk_sel(erase_blk_sel),
    .ro_mask(ro_mask), .xo_mask(xo_mask), .viol_clr(viol_clr), .fetch_rsp(fetch_rsp), .data_rsp(data_rsp),
    .dbg_rsp(dbg_rsp), .erase_busy(erase_busy), .erase_done(erase_done), .viol_pulse(viol_pulse),
    .viol_sticky(viol_sticky));
  task automatic check(input string name, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic acc(input src_t s, input logic w, input int wi, input logic [WORD_W-1:0] d, input logic ok);
    mem_rsp_t r;
    host.issue(s, w, ADDR_W'(wi * 4), d);
    #1;
    r = (s == SRC_FETCH) ? fetch_rsp : (s == SRC_DATA) ? data_rsp : dbg_rsp;
    check("ack", {31'h0, r.ack}, {31'h0, ok});
    check("denied", {31'h0, r.denied}, {31'h0, !ok});
    check("viol_pulse", {31'h0, viol_pulse}, {31'h0, !ok});
    check("rdata", r.rdata, (ok && !w) ? exp_mem[wi] : '0);
    if (ok && w)
      exp_mem[wi] = exp_mem[wi] & d;
  endtask
  task automatic erase(input int b, input logic ok);
    int n;
    @(posedge sys_clk);
    erase_blk_sel <= BLK_W'(b);
    erase_req <= 1'b1;
    @(posedge sys_clk);
    erase_req <= 1'b0;
    #1;
    check("erase_busy", {31'h0, erase_busy}, {31'h0, ok});
    check("erase_viol", {31'h0, viol_pulse}, {31'h0, !ok});
    if (ok)
    begin
      n = 1;
      while (erase_done !== 1'b1 && n < 300)
      begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      check("erase_cycles", n, 257);
      check("busy_end", {31'h0, erase_busy}, '0);
      for (int i = 0; i < WPB; i++)
        if (b < 2)
          exp_mem[b * WPB + i] = ERASED_WORD;
    end
  endtask
  initial
  begin
    int wi;
    int n;
    logic [WORD_W-1:0] d;
    void'($urandom(39410));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("reset_busy", {31'h0, erase_busy}, '0);
    check("reset_sticky", {31'h0, viol_sticky}, '0);
    erase(1, 1'b1);
    erase(0, 1'b1);
    for (int i = 0; i < 24; i++)
    begin
      wi = $urandom_range(0, 511);
      d = $urandom;
      acc(SRC_DATA, 1'b1, wi, d, 1'b1);
      acc(src_t'($urandom_range(0, 2)), 1'b0, wi, '0, 1'b1);
    end
    acc(SRC_DEBUG, 1'b1, 300, 32'h0f0f5a5a, 1'b1);
    erase(0, 1'b1);
    // Block 1 must keep its programmed words across the block 0 erase
    for (int i = 0; i < 16; i++)
      acc(SRC_DATA, 1'b0, $urandom_range(0, 511), '0, 1'b1);
    acc(SRC_DATA, 1'b0, 300, '0, 1'b1);
    @(posedge sys_clk);
    ro_mask <= 16'h0001;
    acc(SRC_DATA, 1'b1, 300, '0, 1'b0);
    acc(SRC_DEBUG, 1'b1, 5, '0, 1'b0);
    erase(1, 1'b0);
    acc(SRC_DATA, 1'b0, 300, '0, 1'b1);
    acc(SRC_DEBUG, 1'b0, 5, '0, 1'b1);
    erase(2, 1'b1);
    check("sticky", {31'h0, viol_sticky}, 32'h1);
    @(posedge sys_clk);
    viol_clr <= 1'b1;
    @(posedge sys_clk);
    viol_clr <= 1'b0;
    ro_mask <= 16'h0000;
    xo_mask <= 16'h0001;
    #1;
    check("sticky_clr", {31'h0, viol_sticky}, '0);
    acc(SRC_DATA, 1'b1, 300, '0, 1'b0);
    erase(0, 1'b0);
    for (int s = 0; s < 3; s++)
      acc(src_t'(s), 1'b0, 300, '0, s == 0);
    acc(SRC_FETCH, 1'b0, 5, '0, 1'b1);
    // A refusal in the same cycle as a clear must leave the flag set
    @(posedge sys_clk);
    viol_clr <= 1'b1;
    acc(SRC_DATA, 1'b0, 300, '0, 1'b0);
    check("sticky_set_wins", {31'h0, viol_sticky}, 32'h1);
    @(posedge sys_clk);
    viol_clr <= 1'b0;
    #1;
    check("sticky_clr2", {31'h0, viol_sticky}, '0);
    // Frozen clock enable stretches an erase by exactly the frozen cycles
    @(posedge sys_clk);
    erase_blk_sel <= BLK_W'(4);
    erase_req <= 1'b1;
    @(posedge sys_clk);
    erase_req <= 1'b0;
    clk_en <= 1'b0;
    repeat (20) @(posedge sys_clk);
    clk_en <= 1'b1;
    #1;
    check("frozen_busy", {31'h0, erase_busy}, 32'h1);
    n = 21;
    while (erase_done !== 1'b1 && n < 320)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("frozen_cycles", n, 277);
    check("frozen_end", {31'h0, erase_busy}, '0);
    finish_test();
  end
  // Run needs about 1500 cycles; the limit leaves generous slack
  initial
  begin
    #1000000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
